// *** design/dimc_ctrl.sv ***
// Module: APB control register with interrupt, DMA and port-enable logic.
`timescale 1ns/1ps
module dimc_ctrl
   import dimc_pkg::*;
(
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Events and clear strobes from board logic on pclk.
   input  wire dimc_evt_t   evt,
   input  wire dimc_clr_t   clr,
   input  wire logic        sample_marked,
   // Digital output register value and the eight lines.
   input  wire logic [7:0]  dout_val,
   input  wire logic [7:0]  dio_in,
   output logic [3:0]       upper_digital_lines_o,
   output logic             upper_digital_lines_oe,
   output logic [3:0]       lower_digital_lines_o,
   output logic             lower_digital_lines_oe,
   // Requests and configuration outputs.
   output logic             drq_a,
   output logic             drq_b,
   output logic             irq,
   output logic [3:0]       irq_level,
   output logic             link_send,
   output logic             sense_ground_drive
);

   // =====================================================================
   // Bus slave
   // =====================================================================
   dimc_ctrl_t  ctrl_q;      // Control word.
   dimc_route_t route;       // Decoded routing, one cycle behind ctrl_q.
   logic        acc;         // Access phase in progress.
   logic        done;        // Access completes at this edge.
   logic        wr_ctrl;     // Write to the control word takes effect.
   logic        map_hit;     // Address is one of ours.
   logic [31:0] stat;        // Status word for readback.
   logic [7:0]  dio_s1_q;    // First synchroniser stage of the lines.
   logic [7:0]  dio_s2_q;    // Second stage, safe to read.
   logic        tc_pend_q;   // Terminal count interrupt pending.
   logic        out_pend_q;  // Output sequence interrupt pending.
   logic        acq_pend_q;  // Acquisition interrupt pending.
   logic        io_irq_q;    // Converter or timer interrupt level.
   logic        turn_b_q;    // Channel B owns the double buffer.

   // Every access phase takes two cycles: pready rises in the second.
   always_comb begin
      acc     = psel & penable;
      done    = acc & pready;
      map_hit = (paddr == DIMC_CTRL_OFS) | (paddr == DIMC_STAT_OFS);
      wr_ctrl = done & pwrite & (paddr == DIMC_CTRL_OFS);
      stat    = {18'h00000, turn_b_q, io_irq_q, acq_pend_q, out_pend_q,
                 tc_pend_q, 1'b0, dio_s2_q[7:4], dio_s2_q[3:0]};
   end

   // Answer one cycle into the access phase, flag unknown addresses.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= acc & ~pready;
         pslverr <= acc & ~pready & ~map_hit;
      end
   end

   // Only the status offset yields data; the control word is write-only.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= DIMC_RD_ZERO;
      end else if (acc & ~pready & ~pwrite & (paddr == DIMC_STAT_OFS)) begin
         prdata <= stat;
      end else begin
         prdata <= DIMC_RD_ZERO;
      end
   end

   // The control word changes only on a completed write to its offset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= dimc_ctrl_t'(DIMC_CTRL_RST);
      end else if (wr_ctrl) begin
         ctrl_q <= dimc_ctrl_t'(pwdata[15:0]);
      end
   end

   // Line levels come from outside, so two stages before anyone looks.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dio_s1_q <= 8'h00;
         dio_s2_q <= 8'h00;
      end else begin
         dio_s1_q <= dio_in;
         dio_s2_q <= dio_s1_q;
      end
   end

   // =====================================================================
   // Mode decode
   // =====================================================================
   dimc_mode_dec u_dec (
      .pclk    (pclk),
      .presetn (presetn),
      .ctrl    (ctrl_q),
      .route_q (route)
   );

   // =====================================================================
   // Pending interrupts
   // =====================================================================
   logic tc_set;   // Terminal count may set its flag.
   logic out_set;  // Output sequence end may set its flag.
   logic acq_set;  // Acquisition end may set its flag.
   logic out_clr;  // Either of the two output clears.

   always_comb begin
      tc_set  = evt.tc & ctrl_q.terminal_count_irq_en;
      out_set = evt.out_done & ctrl_q.output_done_irq_en;
      acq_set = evt.acq_done & ctrl_q.acq_done_irq_en;
      out_clr = clr.timer_request_clear | clr.out_clear;
   end

   // A new event in the clear cycle wins, so none is lost.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tc_pend_q <= 1'b0;
      end else if (tc_set) begin
         tc_pend_q <= 1'b1;
      end else if (clr.terminal_count_clear) begin
         tc_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_pend_q <= 1'b0;
      end else if (out_set) begin
         out_pend_q <= 1'b1;
      end else if (out_clr) begin
         out_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acq_pend_q <= 1'b0;
      end else if (acq_set) begin
         acq_pend_q <= 1'b1;
      end else if (clr.acq_clear) begin
         acq_pend_q <= 1'b0;
      end
   end

   // =====================================================================
   // Request sources
   // =====================================================================
   logic adc_rq;     // Conversion result ready and enabled.
   logic o0_rq;      // Output 0 ready and enabled.
   logic o1_rq;      // Output 1 ready and enabled.

   always_comb begin
      adc_rq    = evt.conv_avail & ctrl_q.conv_result_req_en;
      o0_rq     = evt.out0_ready & ctrl_q.out0_req_en;
      o1_rq     = evt.out1_ready & ctrl_q.out1_req_en;
   end

   // Picks the request condition that one routed channel follows.
   function automatic logic src_rq(input dimc_src_t s, input logic a,
                                   input logic z, input logic o);
      logic r;
      r = 1'b0;
      unique case (s)
         DIMC_SRC_NONE: r = 1'b0;
         DIMC_SRC_ADC:  r = a;
         DIMC_SRC_OUT0: r = z;
         DIMC_SRC_OUT1: r = o;
         DIMC_SRC_BOTH: r = z | o;
         default:       r = 1'b0;
      endcase
      return r;
   endfunction : src_rq

   // In double-buffered modes each terminal count hands the stream over.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         turn_b_q <= 1'b0;
      end else if (!route.dbuf) begin
         turn_b_q <= 1'b0;
      end else if (evt.tc) begin
         turn_b_q <= ~turn_b_q;
      end
   end

   // DMA requests: source readiness, then the channel enables as gates.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drq_a <= 1'b0;
         drq_b <= 1'b0;
      end else begin
         drq_a <= ctrl_q.primary_req_en & ~(route.dbuf & turn_b_q) &
                  src_rq(route.src_a, adc_rq, o0_rq, o1_rq);
         drq_b <= ctrl_q.secondary_req_en & ~(route.dbuf & ~turn_b_q) &
                  src_rq(route.src_b, adc_rq, o0_rq, o1_rq);
      end
   end

   // Converter and timer interrupts exist only while bit 9 is set.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         io_irq_q <= 1'b0;
      end else begin
         io_irq_q <= ctrl_q.io_irq_en &
                     ((route.adc_irq & adc_rq) |
                      (route.tmr_irq & (o0_rq | o1_rq)));
      end
   end

   // =====================================================================
   // Interrupt line and level
   // =====================================================================
   // Maps the three select bits to the host interrupt level number.
   function automatic logic [3:0] lvl(input logic [2:0] s);
      logic [3:0] l;
      l = 4'h3;
      unique case (s)
         3'h0: l = 4'h3;
         3'h1: l = 4'h4;
         3'h2: l = 4'h5;
         3'h3: l = 4'h7;
         3'h4: l = 4'hA;
         3'h5: l = 4'hB;
         3'h6: l = 4'hC;
         3'h7: l = 4'hF;
      endcase
      return l;
   endfunction : lvl

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq       <= 1'b0;
         irq_level <= 4'h3;
      end else begin
         irq       <= tc_pend_q | out_pend_q | acq_pend_q | io_irq_q;
         irq_level <= lvl(ctrl_q.irq_level_sel);
      end
   end

   // =====================================================================
   // Ports, link and sense drive
   // =====================================================================
   // A released port leaves its lines to an outside driver.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         upper_digital_lines_o  <= 4'h0;
         upper_digital_lines_oe <= 1'b0;
         lower_digital_lines_o  <= 4'h0;
         lower_digital_lines_oe <= 1'b0;
      end else begin
         upper_digital_lines_o  <= dout_val[7:4];
         upper_digital_lines_oe <= ctrl_q.upper_port_drive_en;
         lower_digital_lines_o  <= dout_val[3:0];
         lower_digital_lines_oe <= ctrl_q.lower_port_drive_en;
      end
   end

   // A marked sample goes out only while the link is enabled.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link_send          <= 1'b0;
         sense_ground_drive <= 1'b0;
      end else begin
         link_send          <= ctrl_q.adc_serial_link_en & sample_marked;
         sense_ground_drive <= ctrl_q.sense_ground_drive;
      end
   end

   // =====================================================================
   // Assertions
   // =====================================================================
   sequence s_ctrl_write;
      psel & penable & pready & pwrite & (paddr == DIMC_CTRL_OFS);
   endsequence

   property p_ctrl_load;
      @(posedge pclk) disable iff (!presetn)
      s_ctrl_write |=> (ctrl_q == dimc_ctrl_t'($past(pwdata[15:0])));
   endproperty
   a_ctrl_load: assert property (p_ctrl_load)
      else $error("control word not loaded by write");

   property p_link;
      @(posedge pclk) disable iff (!presetn)
      link_send |-> $past(ctrl_q.adc_serial_link_en & sample_marked);
   endproperty
   a_link: assert property (p_link)
      else $error("link sent while disabled or unmarked");

   property p_upper;
      @(posedge pclk) disable iff (!presetn)
      ##1 upper_digital_lines_oe == $past(ctrl_q.upper_port_drive_en);
   endproperty
   a_upper: assert property (p_upper)
      else $error("upper port enable wrong");

   property p_lower;
      @(posedge pclk) disable iff (!presetn)
      ##1 lower_digital_lines_oe == $past(ctrl_q.lower_port_drive_en);
   endproperty
   a_lower: assert property (p_lower)
      else $error("lower port enable wrong");

   property p_tc;
      @(posedge pclk) disable iff (!presetn)
      tc_set |=> tc_pend_q ##1 irq;
   endproperty
   a_tc: assert property (p_tc)
      else $error("terminal count did not raise interrupt");

   property p_tc_clr;
      @(posedge pclk) disable iff (!presetn)
      (clr.terminal_count_clear & ~tc_set) |=> !tc_pend_q;
   endproperty
   a_tc_clr: assert property (p_tc_clr)
      else $error("terminal count flag not cleared");

   property p_out_clr;
      @(posedge pclk) disable iff (!presetn)
      (out_clr & ~out_set) |=> !out_pend_q;
   endproperty
   a_out_clr: assert property (p_out_clr)
      else $error("output flag not cleared");

   property p_acq;
      @(posedge pclk) disable iff (!presetn)
      (evt.acq_done & ~ctrl_q.acq_done_irq_en & ~acq_pend_q) |=> !acq_pend_q;
   endproperty
   a_acq: assert property (p_acq)
      else $error("acquisition flag set while disabled");

   property p_drq_gate;
      @(posedge pclk) disable iff (!presetn)
      (drq_a |-> $past(ctrl_q.primary_req_en)) and
      (drq_b |-> $past(ctrl_q.secondary_req_en));
   endproperty
   a_drq_gate: assert property (p_drq_gate)
      else $error("request on a disabled channel");

   property p_level;
      @(posedge pclk) disable iff (!presetn)
      (ctrl_q.irq_level_sel == 3'h7) [*2] |-> irq_level == 4'hF;
   endproperty
   a_level: assert property (p_level)
      else $error("interrupt level mismatch");

endmodule : dimc_ctrl

// *** design/dimc_mode_dec.sv ***
// Module: registered decoder from mode bits to channel routing.
`timescale 1ns/1ps
module dimc_mode_dec
   import dimc_pkg::*;
(
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Mode bits in, routing out.
   input  wire dimc_ctrl_t  ctrl,
   output dimc_route_t      route_q
);

   // =====================================================================
   // Mode table
   // =====================================================================
   // Builds one routing entry.
   // Flag arguments are ints so the table rows stay short; bit 0 is used.
   function automatic dimc_route_t mk(input dimc_src_t a, input dimc_src_t b,
                                      input int d, input int ai,
                                      input int ti);
      dimc_route_t r;
      r = '{src_a: a, src_b: b, dbuf: d[0], adc_irq: ai[0], tmr_irq: ti[0]};
      return r;
   endfunction : mk

   logic [5:0]  key;     // Interrupt, channel and request bits joined.
   dimc_route_t route_d; // Decoded routing.

   // Unlisted patterns route nothing, so a bad write stays harmless.
   always_comb begin
      key = {ctrl.io_irq_en, ctrl.primary_req_en, ctrl.secondary_req_en,
             ctrl.conv_result_req_en, ctrl.out1_req_en, ctrl.out0_req_en};
      route_d = mk(DIMC_SRC_NONE, DIMC_SRC_NONE, 1'b0, 1'b0, 1'b0);
      unique case (key)
         // Channel A alone.
         6'b010001: route_d = mk(DIMC_SRC_OUT0, DIMC_SRC_NONE, 0, 0, 0);
         6'b010010: route_d = mk(DIMC_SRC_OUT1, DIMC_SRC_NONE, 0, 0, 0);
         6'b010011: route_d = mk(DIMC_SRC_BOTH, DIMC_SRC_NONE, 0, 0, 0);
         6'b010100: route_d = mk(DIMC_SRC_ADC, DIMC_SRC_NONE, 0, 0, 0);
         // Channel B alone.
         6'b001001: route_d = mk(DIMC_SRC_NONE, DIMC_SRC_OUT0, 0, 0, 0);
         6'b001010: route_d = mk(DIMC_SRC_NONE, DIMC_SRC_OUT1, 0, 0, 0);
         6'b001011: route_d = mk(DIMC_SRC_NONE, DIMC_SRC_BOTH, 0, 0, 0);
         6'b001100: route_d = mk(DIMC_SRC_NONE, DIMC_SRC_ADC, 0, 0, 0);
         // Both channels.
         6'b011000: route_d = mk(DIMC_SRC_BOTH, DIMC_SRC_BOTH, 1, 0, 0);
         6'b011001: route_d = mk(DIMC_SRC_OUT0, DIMC_SRC_OUT0, 1, 0, 0);
         6'b011010: route_d = mk(DIMC_SRC_OUT1, DIMC_SRC_OUT1, 1, 0, 0);
         6'b011011: route_d = mk(DIMC_SRC_OUT0, DIMC_SRC_OUT1, 0, 0, 0);
         6'b011100: route_d = mk(DIMC_SRC_ADC, DIMC_SRC_ADC, 1, 0, 0);
         6'b011101: route_d = mk(DIMC_SRC_ADC, DIMC_SRC_OUT0, 0, 0, 0);
         6'b011110: route_d = mk(DIMC_SRC_ADC, DIMC_SRC_OUT1, 0, 0, 0);
         6'b011111: route_d = mk(DIMC_SRC_ADC, DIMC_SRC_BOTH, 0, 0, 0);
         // Interrupt modes, optionally with DMA on one or both channels.
         6'b100001,
         6'b100010,
         6'b100011: route_d = mk(DIMC_SRC_NONE, DIMC_SRC_NONE, 0, 0, 1);
         6'b100100: route_d = mk(DIMC_SRC_NONE, DIMC_SRC_NONE, 0, 1, 0);
         6'b100101,
         6'b100110,
         6'b100111: route_d = mk(DIMC_SRC_NONE, DIMC_SRC_NONE, 0, 1, 1);
         6'b110001: route_d = mk(DIMC_SRC_OUT0, DIMC_SRC_NONE, 0, 1, 0);
         6'b110010: route_d = mk(DIMC_SRC_OUT1, DIMC_SRC_NONE, 0, 1, 0);
         6'b110011: route_d = mk(DIMC_SRC_BOTH, DIMC_SRC_NONE, 0, 1, 0);
         6'b110100: route_d = mk(DIMC_SRC_ADC, DIMC_SRC_NONE, 0, 0, 1);
         6'b101001: route_d = mk(DIMC_SRC_NONE, DIMC_SRC_OUT0, 0, 1, 0);
         6'b101010: route_d = mk(DIMC_SRC_NONE, DIMC_SRC_OUT1, 0, 1, 0);
         6'b101011: route_d = mk(DIMC_SRC_NONE, DIMC_SRC_BOTH, 0, 1, 0);
         6'b101100: route_d = mk(DIMC_SRC_NONE, DIMC_SRC_ADC, 0, 0, 1);
         6'b111001: route_d = mk(DIMC_SRC_OUT0, DIMC_SRC_OUT0, 1, 1, 0);
         6'b111010: route_d = mk(DIMC_SRC_OUT1, DIMC_SRC_OUT1, 1, 1, 0);
         6'b111011: route_d = mk(DIMC_SRC_OUT0, DIMC_SRC_OUT1, 0, 1, 0);
         6'b111100: route_d = mk(DIMC_SRC_ADC, DIMC_SRC_ADC, 1, 0, 1);
         6'b111101: route_d = mk(DIMC_SRC_OUT0, DIMC_SRC_ADC, 0, 0, 0);
         6'b111110: route_d = mk(DIMC_SRC_OUT1, DIMC_SRC_ADC, 0, 0, 0);
         6'b111111: route_d = mk(DIMC_SRC_BOTH, DIMC_SRC_ADC, 0, 0, 0);
         default:   route_d = mk(DIMC_SRC_NONE, DIMC_SRC_NONE, 0, 0, 0);
      endcase
   end

   // Registering the table keeps the long decode off the request path.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         route_q <= mk(DIMC_SRC_NONE, DIMC_SRC_NONE, 1'b0, 1'b0, 1'b0);
      end else begin
         route_q <= route_d;
      end
   end

endmodule : dimc_mode_dec

// *** design/dimc_pkg.sv ***
// Package: constants and types of the DMA and interrupt mode control block.
package dimc_pkg;

   // =====================================================================
   // Register map and reset values
   // =====================================================================
   localparam logic [7:0]  DIMC_CTRL_OFS  = 8'h04; // Control, write-only.
   localparam logic [7:0]  DIMC_STAT_OFS  = 8'h08; // Status, read-only.
   localparam logic [15:0] DIMC_CTRL_RST  = 16'h0000;
   localparam logic [31:0] DIMC_RD_ZERO   = 32'h0000_0000;

   // =====================================================================
   // Types
   // =====================================================================
   // Control word, most significant bit first.
   typedef struct packed {
      logic       adc_serial_link_en;
      logic       upper_port_drive_en;
      logic       lower_port_drive_en;
      logic       terminal_count_irq_en;
      logic       output_done_irq_en;
      logic       acq_done_irq_en;
      logic       io_irq_en;
      logic       primary_req_en;
      logic       secondary_req_en;
      logic       conv_result_req_en;
      logic       out1_req_en;
      logic       out0_req_en;
      logic       sense_ground_drive;
      logic [2:0] irq_level_sel;
   } dimc_ctrl_t;

   // Data source or sink served by one DMA channel, one-hot.
   typedef enum logic [4:0] {
      DIMC_SRC_NONE = 5'b00001,
      DIMC_SRC_ADC  = 5'b00010,
      DIMC_SRC_OUT0 = 5'b00100,
      DIMC_SRC_OUT1 = 5'b01000,
      DIMC_SRC_BOTH = 5'b10000
   } dimc_src_t;

   // Decoded routing of both channels and interrupt sources.
   typedef struct packed {
      dimc_src_t src_a;
      dimc_src_t src_b;
      logic      dbuf;      // Channels take turns on one stream.
      logic      adc_irq;   // Conversion results raise an interrupt.
      logic      tmr_irq;   // Output updates raise an interrupt.
   } dimc_route_t;

   // Hardware events, one-cycle pulses except the three levels.
   typedef struct packed {
      logic tc;          // Terminal count from the host DMA controller.
      logic out_done;    // Output sequence ended or underflowed.
      logic acq_done;    // Acquisition ended, overran or overflowed.
      logic conv_avail;  // Converter FIFO holds a result (level).
      logic out0_ready;  // Output converter 0 wants data (level).
      logic out1_ready;  // Output converter 1 wants data (level).
   } dimc_evt_t;

   // Clear strobes from the neighbouring clear registers.
   typedef struct packed {
      logic terminal_count_clear;
      logic timer_request_clear;
      logic out_clear;
      logic acq_clear;
   } dimc_clr_t;

endpackage : dimc_pkg

// *** verif/dimc_ctrl_bench.sv ***
// Self-checking bench of the control block against a table model.
`timescale 1ns/1ps
module dimc_ctrl_bench;
   import dimc_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic sample_marked = 0, pready, pslverr, er, tc_h;
   logic [7:0] paddr = 0, dout_val = 0, dio_in = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [5:0] ev = 0;
   logic [3:0] cl = 0, upper_digital_lines_o, lower_digital_lines_o;
   logic [3:0] irq_level;
   logic upper_digital_lines_oe, lower_digital_lines_oe, sense_ground_drive;
   logic drq_a, drq_b, irq, link_send;
   dimc_evt_t evt;
   dimc_clr_t clr;
   bit [31:0] seed = 32'h00005C4E;
   int n_fail = 0, n_tests = 0, k;
   int lv [8] = '{3, 4, 5, 7, 10, 11, 12, 15};   // Level of each code.
   int eb [3] = '{12, 11, 10};                   // Enable bit per source.
   logic [5:0] evs [3] = '{6'h20, 6'h10, 6'h08};  // Event per source.
   logic [3:0] cls [3] = '{4'h8, 4'h4, 4'h1};     // Clear per source.
   assign evt = dimc_evt_t'(ev | {tc_h, 5'h00});
   assign clr = dimc_clr_t'(cl);
   always #20 pclk = ~pclk;
   dimc_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .evt, .clr, .sample_marked,
      .dout_val, .dio_in, .upper_digital_lines_o, .upper_digital_lines_oe,
      .lower_digital_lines_o, .lower_digital_lines_oe, .drq_a, .drq_b, .irq,
      .irq_level, .link_send, .sense_ground_drive);
   dimc_host_dma u_host (.pclk, .presetn, .drq(drq_a | drq_b), .tc(tc_h));
   function automatic bit [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task give_verdict;
      if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   task chk(input logic [32:0] g, input logic [32:0] e);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask : chk
   task wt(input int n);
      repeat (n) @(posedge pclk);
   endtask : wt
   // One APB transfer; the answer is taken at the pready edge only.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      i = 0;
      do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 20);
      if (i >= 20) begin n_fail++; give_verdict(); end
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask : apb
   task pulse(input logic [5:0] e, input logic [3:0] c);
      ev <= e;
      cl <= c;
      @(posedge pclk);
      ev <= 0;
      cl <= 0;
   endtask : pulse
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1;
      wt(1);
      chk({upper_digital_lines_oe, lower_digital_lines_oe, irq_level}, 6'h03);
      rd = xs();
      dout_val <= rd[7:0];
      dio_in <= rd[15:8];
      apb(1, DIMC_CTRL_OFS, {rd[31:16], 16'h6008});
      wt(2);
      chk({upper_digital_lines_o, upper_digital_lines_oe, lower_digital_lines_o, lower_digital_lines_oe, sense_ground_drive}, {dout_val[7:4], 1'b1, dout_val[3:0], 2'b11});
      apb(1, DIMC_CTRL_OFS, 32'h0);
      wt(2);
      chk({upper_digital_lines_oe, lower_digital_lines_oe}, 2'b00);
      for (k = 0; k < 8; k++) begin
         apb(1, DIMC_CTRL_OFS, 32'(k));
         wt(2);
         chk(irq_level, 33'(lv[k]));
      end
      apb(0, DIMC_CTRL_OFS, 32'h0);
      chk({er, rd}, 33'h0);
      apb(0, 8'h40, 32'h0);
      chk(er, 1'b1);
      // Each completion source: raise, clear, then stay quiet when disabled.
      for (k = 0; k < 3; k++) begin
         apb(1, DIMC_CTRL_OFS, 32'h1 << eb[k]);
         pulse(evs[k], 4'h0);
         wt(2);
         chk(irq, 1'b1);
         pulse(6'h00, cls[k]);
         wt(2);
         chk(irq, 1'b0);
         apb(1, DIMC_CTRL_OFS, 32'h0);
         pulse(evs[k], 4'h0);
         wt(2);
         chk(irq, 1'b0);
      end
      ev <= 6'h02;
      apb(1, DIMC_CTRL_OFS, 32'h0110);
      wt(4);
      chk({drq_a, drq_b}, 2'b10);
      apb(1, DIMC_CTRL_OFS, 32'h0090);
      wt(4);
      chk({drq_a, drq_b}, 2'b01);
      apb(1, DIMC_CTRL_OFS, 32'h0010);
      wt(4);
      chk({drq_a, drq_b}, 2'b00);
      ev <= 6'h04;
      apb(1, DIMC_CTRL_OFS, 32'h01C0);
      wt(4);
      chk(drq_a ^ drq_b, 1'b1);
      apb(1, DIMC_CTRL_OFS, 32'h0240);
      wt(4);
      chk(irq, 1'b1);
      apb(0, DIMC_STAT_OFS, 32'h0);
      chk({rd[12], rd[7:0]}, {1'b1, dio_in});
      ev <= 6'h00;
      apb(1, DIMC_CTRL_OFS, 32'h0800);
      pulse(6'h10, 4'h0);
      wt(2);
      chk(irq, 1'b1);
      pulse(6'h00, 4'h2);
      wt(2);
      chk(irq, 1'b0);
      sample_marked <= 1;
      apb(1, DIMC_CTRL_OFS, 32'h8000);
      wt(3);
      chk(link_send, 1'b1);
      apb(1, DIMC_CTRL_OFS, 32'h0);
      wt(3);
      chk(link_send, 1'b0);
      give_verdict();
   end
endmodule : dimc_ctrl_bench

// *** verif/dimc_host_dma.sv ***
// Host DMA controller model that closes each block with a terminal count.
`timescale 1ns/1ps
module dimc_host_dma (
   // Clock, reset and request from the board.
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic drq,
   // Terminal count pulse back to the board.
   output logic      tc
);
   logic [2:0] n_q;   // Transfers served in the current block.
   // Every eighth served request is the final one of a block.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         n_q <= 3'h0;
         tc  <= 1'b0;
      end else begin
         tc  <= drq && (n_q == 3'h7);
         n_q <= drq ? n_q + 3'h1 : n_q;
      end
   end
endmodule : dimc_host_dma
